// ==== hdl/fpmm_classify.v ====
`timescale 1ns/1ps
`include "fpmm_regs.vh"
// Flags NaN kinds and splits sign and magnitude for either format
module fpmm_classify (
  input  wire [63:0] operand,
  input  wire        isDouble,
  output reg         isNan,
  output reg         isSnan,
  output reg         sign,
  output reg  [62:0] magnitude
);
  reg expOnes;
  reg fracNz;
  reg qBit;
  always @* begin
    expOnes = 1'b0;
    fracNz = 1'b0;
    qBit = 1'b0;
    if (isDouble) begin
      expOnes = &operand[`FPMM_DP_EXP_HI:`FPMM_DP_EXP_LO];
      fracNz = |operand[`FPMM_DP_EXP_LO-1:0];
      qBit = operand[`FPMM_DP_QBIT];
      sign = operand[`FPMM_DP_SIGN];
      magnitude = operand[`FPMM_DP_SIGN-1:0];
    end else begin
      expOnes = &operand[`FPMM_SP_EXP_HI:`FPMM_SP_EXP_LO];
      fracNz = |operand[`FPMM_SP_EXP_LO-1:0];
      qBit = operand[`FPMM_SP_QBIT];
      sign = operand[`FPMM_SP_SIGN];
      magnitude = {32'h00000000, operand[`FPMM_SP_SIGN-1:0]};
    end
    isNan = expOnes & fracNz;
    isSnan = expOnes & fracNz & ~qBit;
  end
endmodule // fpmm_classify

// ==== hdl/fpmm_regs.vh ====
`ifndef FPMM_REGS_VH
`define FPMM_REGS_VH
`define FPMM_MAJOR_HI      31
`define FPMM_MAJOR_LO      26
`define FPMM_SRC2_HI       25
`define FPMM_SRC2_LO       21
`define FPMM_SRC1_HI       20
`define FPMM_SRC1_LO       16
`define FPMM_DEST_HI       15
`define FPMM_DEST_LO       11
`define FPMM_FMT_HI        10
`define FPMM_FMT_LO        9
`define FPMM_FUNC_HI       8
`define FPMM_FUNC_LO       0
`define FPMM_MAJOR_CODE    6'h15
`define FPMM_FN_MAX        9'h00B
`define FPMM_FN_MAXMAG     9'h02B
`define FPMM_FN_MIN        9'h003
`define FPMM_FN_MINMAG     9'h023
`define FPMM_FMT_SINGLE    2'h0
`define FPMM_FMT_DOUBLE    2'h1
`define FPMM_OP_MAX        2'h0
`define FPMM_OP_MIN        2'h1
`define FPMM_OP_MAXMAG     2'h2
`define FPMM_OP_MINMAG     2'h3
`define FPMM_EXC_NONE      2'h0
`define FPMM_EXC_CPU       2'h1
`define FPMM_EXC_RI        2'h2
`define FPMM_EXC_INVALID   2'h3
`define FPMM_CP_FPU        2'h1
`define FPMM_SP_EXP_HI     30
`define FPMM_SP_EXP_LO     23
`define FPMM_SP_QBIT       22
`define FPMM_DP_EXP_HI     62
`define FPMM_DP_EXP_LO     52
`define FPMM_DP_QBIT       51
`define FPMM_SP_SIGN       31
`define FPMM_DP_SIGN       63
`define FPMM_IRQ_DONE      0
`define FPMM_IRQ_EXC       1
`endif

// ==== hdl/fpmm_select.v ====
`timescale 1ns/1ps
`include "fpmm_regs.vh"
// Ordered selection of two non-NaN operands
module fpmm_select (
  input  wire [1:0]  op,
  input  wire        signA,
  input  wire [62:0] magA,
  input  wire        signB,
  input  wire [62:0] magB,
  output reg         pickB
);
  reg aLess;
  reg magEq;
  always @* begin
    magEq = (magA == magB);
    // Signed order with -0 below +0
    if (signA != signB)
      aLess = signA;
    else if (signA)
      aLess = magA > magB;
    else
      aLess = magA < magB;
    case (op)
      `FPMM_OP_MAX:    pickB = aLess;
      `FPMM_OP_MIN:    pickB = ~aLess & ~(magEq & (signA == signB));
      `FPMM_OP_MAXMAG: pickB = magEq ? (signA & ~signB) : (magA < magB);
      default:         pickB = magEq ? (signB & ~signA) : (magB < magA);
    endcase
  end
endmodule // fpmm_select

// ==== hdl/fpmm_unit.v ====
`timescale 1ns/1ps
`include "fpmm_regs.vh"
// Function
// RULE1 - Decode major group, source, destination, format and function fields of word.
// RULE2 - Function 000001011 is maximum, 000101011 is larger-magnitude select.
// RULE3 - Function 000000011 is minimum, 000100011 is smaller-magnitude select.
// RULE4 - Maximum writes larger operand; positive zero beats negative zero.
// RULE5 - Minimum writes smaller operand; negative zero beats positive zero.
// RULE6 - Larger-magnitude select writes that operand with its own sign.
// RULE7 - Smaller-magnitude select writes that operand with its own sign.
// RULE8 - One NaN source: the numeric operand is the result.
// RULE9 - Both NaN: first source NaN passes unchanged.
// RULE10 - Equal magnitudes in larger-magnitude select give the positive operand.
// RULE11 - Equal magnitudes in smaller-magnitude select give the negative operand.
// RULE12 - Coprocessor disabled: unusable exception for coprocessor 1, no write.
// RULE13 - Unimplemented format raises reserved-instruction exception, no execution.
// RULE14 - Signalling NaN with invalid trap enabled: invalid exception, no write.
// RULE15 - Signalling NaN with trap disabled selects as quiet, never quietened.
// RULE16 - Single and double formats use format codes 0 and 1.
// RULE17 - Selected operand written bit-exact, no rounding.
module fpmm_unit (
  input  wire        clk,
  input  wire        rst,
  input  wire        clkEn,
  input  wire        issueValid,
  input  wire [31:0] instrWord,
  input  wire        cpEnabled,
  input  wire        invalidTrapEn,
  output reg         srcRead,
  output reg  [4:0]  firstSourceReg,
  output reg  [4:0]  secondSourceReg,
  input  wire [63:0] firstSourceData,
  input  wire [63:0] secondSourceData,
  output reg         destWrite,
  output reg  [4:0]  destinationReg,
  output reg  [63:0] destData,
  output reg         done,
  output reg         excValid,
  output reg  [1:0]  excCode,
  output reg  [1:0]  excCopNum,
  output reg         invalidCause,
  input  wire [1:0]  regAddr,
  input  wire [31:0] regWdata,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [31:0] regRdata,
  output reg         irq
);
  localparam ST_IDLE = 1'b0;
  localparam ST_EXEC = 1'b1;
  localparam [1:0] ADDR_STATUS = 2'h0;
  localparam [1:0] ADDR_MASK   = 2'h1;
  localparam [1:0] ADDR_COUNT  = 2'h2;

  reg        state_q;
  reg [1:0]  op_q;
  reg        dbl_q;
  reg [1:0]  status_q;
  reg [1:0]  mask_q;
  reg [15:0] count_q;

  // Operation code for a selection word, valid flag in bit 2
  function [2:0] decodeOp;
    input [31:0] w;
    begin
      decodeOp = 3'h0;
      if (w[`FPMM_MAJOR_HI:`FPMM_MAJOR_LO] == `FPMM_MAJOR_CODE) begin // [RULE1]
        if (w[`FPMM_FUNC_HI:`FPMM_FUNC_LO] == `FPMM_FN_MAX)
          decodeOp = {1'b1, `FPMM_OP_MAX}; // [RULE2]
        else if (w[`FPMM_FUNC_HI:`FPMM_FUNC_LO] == `FPMM_FN_MAXMAG)
          decodeOp = {1'b1, `FPMM_OP_MAXMAG}; // [RULE2]
        else if (w[`FPMM_FUNC_HI:`FPMM_FUNC_LO] == `FPMM_FN_MIN)
          decodeOp = {1'b1, `FPMM_OP_MIN}; // [RULE3]
        else if (w[`FPMM_FUNC_HI:`FPMM_FUNC_LO] == `FPMM_FN_MINMAG)
          decodeOp = {1'b1, `FPMM_OP_MINMAG}; // [RULE3]
      end
    end
  endfunction

  wire [2:0] dec = decodeOp(instrWord);
  wire [1:0] fmt = instrWord[`FPMM_FMT_HI:`FPMM_FMT_LO];
  wire fmtOk = (fmt == `FPMM_FMT_SINGLE) || (fmt == `FPMM_FMT_DOUBLE); // [RULE16]

  wire        nanA;
  wire        snanA;
  wire        signA;
  wire [62:0] magA;
  wire        nanB;
  wire        snanB;
  wire        signB;
  wire [62:0] magB;
  wire        pickB;

  fpmm_classify uClsA (
    .operand   (firstSourceData),
    .isDouble  (dbl_q),
    .isNan     (nanA),
    .isSnan    (snanA),
    .sign      (signA),
    .magnitude (magA)
  );
  fpmm_classify uClsB (
    .operand   (secondSourceData),
    .isDouble  (dbl_q),
    .isNan     (nanB),
    .isSnan    (snanB),
    .sign      (signB),
    .magnitude (magB)
  );
  fpmm_select uSel (
    .op    (op_q),
    .signA (signA),
    .magA  (magA),
    .signB (signB),
    .magB  (magB),
    .pickB (pickB) // [RULE4] [RULE5] [RULE6] [RULE7] [RULE10] [RULE11]
  );

  // NaN preference; signalling NaNs treated as quiet here
  reg useB;
  always @* begin
    if (nanA && nanB)
      useB = 1'b0; // [RULE9]
    else if (nanA)
      useB = 1'b1; // [RULE8]
    else if (nanB)
      useB = 1'b0; // [RULE8]
    else
      useB = pickB;
  end
  wire [63:0] chosen = useB ? secondSourceData : firstSourceData;
  wire        snanAny = snanA | snanB;
  wire        execEnd = (state_q == ST_EXEC);
  wire        excNow = execEnd & snanAny & invalidTrapEn;
  wire        evtDone = execEnd;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      op_q <= `FPMM_OP_MAX;
      dbl_q <= 1'b0;
      srcRead <= 1'b0;
      firstSourceReg <= 5'h00;
      secondSourceReg <= 5'h00;
      destWrite <= 1'b0;
      destinationReg <= 5'h00;
      destData <= 64'h0000000000000000;
      done <= 1'b0;
      excValid <= 1'b0;
      excCode <= `FPMM_EXC_NONE;
      excCopNum <= 2'h0;
      invalidCause <= 1'b0;
    end else if (clkEn) begin
      srcRead <= 1'b0;
      destWrite <= 1'b0;
      done <= 1'b0;
      excValid <= 1'b0;
      invalidCause <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (issueValid && dec[2]) begin
            if (!cpEnabled) begin
              excValid <= 1'b1; // [RULE12]
              excCode <= `FPMM_EXC_CPU;
              excCopNum <= `FPMM_CP_FPU;
              done <= 1'b1;
            end else if (!fmtOk) begin
              excValid <= 1'b1; // [RULE13]
              excCode <= `FPMM_EXC_RI;
              excCopNum <= 2'h0;
              done <= 1'b1;
            end else begin
              state_q <= ST_EXEC;
              op_q <= dec[1:0];
              dbl_q <= (fmt == `FPMM_FMT_DOUBLE); // [RULE16]
              srcRead <= 1'b1;
              firstSourceReg <= instrWord[`FPMM_SRC1_HI:`FPMM_SRC1_LO]; // [RULE1]
              secondSourceReg <= instrWord[`FPMM_SRC2_HI:`FPMM_SRC2_LO];
              destinationReg <= instrWord[`FPMM_DEST_HI:`FPMM_DEST_LO];
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
          done <= 1'b1;
          invalidCause <= snanAny; // [RULE15]
          if (excNow) begin
            excValid <= 1'b1; // [RULE14]
            excCode <= `FPMM_EXC_INVALID;
            excCopNum <= 2'h0;
          end else begin
            destWrite <= 1'b1;
            destData <= dbl_q ? chosen : {32'h00000000, chosen[31:0]}; // [RULE17] [RULE15]
            excCode <= `FPMM_EXC_NONE;
          end
        end
      endcase
    end
  end

  // Status, mask and counter; read of status clears it, set wins
  wire [1:0] evt = {excNow | (state_q == ST_IDLE & issueValid & dec[2] & ~(cpEnabled & fmtOk)),
                    evtDone};
  wire       rdStatus = regRd && (regAddr == ADDR_STATUS);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      status_q <= 2'h0;
      mask_q <= 2'h0;
      count_q <= 16'h0000;
      regRdata <= 32'h00000000;
      irq <= 1'b0;
    end else if (clkEn) begin
      status_q <= (rdStatus ? 2'h0 : status_q) | evt;
      if (regWr && regAddr == ADDR_MASK)
        mask_q <= regWdata[1:0];
      if (regWr && regAddr == ADDR_COUNT)
        count_q <= regWdata[15:0];
      else if (destWrite)
        count_q <= count_q + 16'h0001;
      irq <= |(((rdStatus ? 2'h0 : status_q) | evt) & mask_q);
      if (rdStatus)
        regRdata <= {30'h00000000, status_q};
      else if (regRd && regAddr == ADDR_MASK)
        regRdata <= {30'h00000000, mask_q};
      else if (regRd && regAddr == ADDR_COUNT)
        regRdata <= {16'h0000, count_q};
      else
        regRdata <= 32'h00000000;
    end
  end
endmodule // fpmm_unit

// ==== verification/fpmm_props.sv ====
`timescale 1ns/1ps
module fpmm_props (
  input        clk,
  input        rst,
  input        clkEn,
  input        issueValid,
  input [31:0] instrWord,
  input        cpEnabled,
  input        invalidTrapEn,
  input        srcRead,
  input [4:0]  firstSourceReg,
  input [4:0]  secondSourceReg,
  input [63:0] firstSourceData,
  input [63:0] secondSourceData,
  input        destWrite,
  input [4:0]  destinationReg,
  input [63:0] destData,
  input        done,
  input        excValid,
  input [1:0]  excCode,
  input [1:0]  excCopNum,
  input        invalidCause
);
  reg dblQ;
  wire [8:0] fn = instrWord[8:0];
  wire sel = instrWord[31:26] == 6'h15 &&
    (fn == 9'h00B || fn == 9'h02B || fn == 9'h003 || fn == 9'h023);
  // Bit 1 any NaN, bit 0 signalling NaN
  function [1:0] kind(input [63:0] v, input d);
    kind = d ? {&v[62:52] && |v[51:0], &v[62:52] && !v[51] && |v[50:0]}
             : {&v[30:23] && |v[22:0], &v[30:23] && !v[22] && |v[21:0]};
  endfunction
  wire [1:0] k1 = kind(firstSourceData, dblQ);
  wire [1:0] k2 = kind(secondSourceData, dblQ);
  wire trap = invalidTrapEn && (k1[0] || k2[0]);
  wire [63:0] a = dblQ ? firstSourceData : {32'h0, firstSourceData[31:0]};
  wire [63:0] b = dblQ ? secondSourceData : {32'h0, secondSourceData[31:0]};
  always @(posedge clk or posedge rst)
    if (rst) dblQ <= 1'b0;
    else dblQ <= instrWord[9];
  default clocking @(posedge clk); endclocking
  // Frozen cycles carry no checks
  default disable iff (rst || !clkEn);
  src_fields_a: assert property (srcRead |->
    firstSourceReg == $past(instrWord[20:16]) && secondSourceReg == $past(instrWord[25:21]))
    else $error("source fields wrong");
  dest_field_a: assert property (destWrite |->
    destinationReg == $past(instrWord[15:11], 2)) else $error("destination field wrong");
  other_ignored_a: assert property (!(issueValid && sel) |=> !srcRead)
    else $error("foreign word executed");
  cop_off_a: assert property (issueValid && sel && !srcRead && !cpEnabled |=>
    excValid && excCode == 2'h1 && excCopNum == 2'h1 && done && !destWrite)
    else $error("cop check lost");
  bad_fmt_a: assert property (cpEnabled && instrWord[10] &&
    issueValid && sel && !srcRead |=> excValid && excCode == 2'h2 && !destWrite)
    else $error("format check lost");
  sn_trap_a: assert property (srcRead && trap |=>
    excValid && excCode == 2'h3 && !destWrite) else $error("trap not taken");
  write_done_a: assert property (srcRead && !trap |=> destWrite && done && !excValid)
    else $error("no write");
  both_nan_a: assert property (srcRead && !trap && k1[1] && k2[1] |=>
    destData == $past(a)) else $error("first NaN not kept");
  one_nan_a: assert property (srcRead && !trap && k1[1] != k2[1] |=>
    destData == $past(k1[1] ? b : a)) else $error("number not preferred");
  sn_seen_a: assert property (srcRead |=> invalidCause == $past(k1[0] || k2[0]))
    else $error("signalling NaN not flagged");
  cover property (srcRead && k1[1] && k2[1]);
  cover property (excValid && excCode == 2'h3);
  cover property (excValid && excCode == 2'h1);
endmodule // fpmm_props
bind fpmm_unit fpmm_props chk (.*);

// ==== verification/fpmm_rf_model.sv ====
`timescale 1ns/1ps
module fpmm_rf_model (
  input         clk,
  input         srcRead,
  input  [4:0]  firstSourceReg,
  input  [4:0]  secondSourceReg,
  input         destWrite,
  input  [4:0]  destinationReg,
  input  [63:0] destData,
  output [63:0] firstSourceData,
  output [63:0] secondSourceData
);
  reg [63:0] mem [0:31];
  reg        junk = 1'b0;
  // Unread ports show a toggling pattern
  always @(posedge clk) junk <= ~junk;
  always @(posedge clk) if (destWrite) mem[destinationReg] <= destData;
  assign firstSourceData  = srcRead ? mem[firstSourceReg] : {64{junk}};
  assign secondSourceData = srcRead ? mem[secondSourceReg] : {64{~junk}};
endmodule // fpmm_rf_model

// ==== verification/fpmm_tb.sv ====
`timescale 1ns/1ps
module testbench;
  logic clk = 0, rst = 1, issueValid = 0, cpEnabled = 1, invalidTrapEn = 0;
  logic regWr = 0, regRd = 0, rdP = 0, clkEn = 1;
  logic [31:0] instrWord = 0, regWdata = 0;
  logic [1:0]  regAddr = 0;
  wire srcRead, destWrite, done, excValid, invalidCause, irq;
  wire [4:0]  firstSourceReg, secondSourceReg, destinationReg;
  wire [63:0] firstSourceData, secondSourceData, destData;
  wire [1:0]  excCode, excCopNum;
  wire [31:0] regRdata;
  int error_cnt = 0, checks_done = 0, nw = 0;
  logic [72:0] rq[$];
  logic [31:0] gq[$];
  fpmm_unit dut (.*);
  fpmm_rf_model rf (.*);
  always #5 clk = ~clk;
  task chkRes(input [72:0] g, e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t result %h expected %h", $time, g, e);
    end
  endtask
  task chkWord(input [31:0] g, e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t word %h expected %h", $time, g, e);
    end
  endtask
  task close_out;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  function logic sn(input [63:0] v, input d);
    return d ? &v[62:52] && !v[51] && |v[50:0] : &v[30:23] && !v[22] && |v[21:0];
  endfunction
  function logic [63:0] refv(input [1:0] op, input d, input [63:0] x, y);
    logic [62:0] ma, mb, inf;
    logic sa, sb, pb;
    inf = d ? 63'h7FF0000000000000 : 63'h7F800000;
    ma = d ? x[62:0] : 63'(x[30:0]);
    mb = d ? y[62:0] : 63'(y[30:0]);
    sa = d ? x[63] : x[31];
    sb = d ? y[63] : y[31];
    case (op)
      2'h0: pb = sa != sb ? sa : (sa ? mb < ma : mb > ma);
      2'h1: pb = sa != sb ? sb : (sa ? mb > ma : mb < ma);
      2'h2: pb = mb > ma || (mb == ma && sa && !sb);
      default: pb = mb < ma || (mb == ma && !sa && sb);
    endcase
    if (ma > inf) pb = mb <= inf;
    else if (mb > inf) pb = 1'b0;
    return pb ? (d ? y : {32'h0, y[31:0]}) : (d ? x : {32'h0, x[31:0]});
  endfunction
  task wr(input [1:0] ad, input [31:0] v);
    @(posedge clk);
    regWr <= 1; regAddr <= ad; regWdata <= v;
    @(posedge clk);
    regWr <= 0;
  endtask
  task rd(input [1:0] ad, input [31:0] ex);
    @(posedge clk);
    regRd <= 1; regAddr <= ad; gq.push_back(ex);
    @(posedge clk);
    regRd <= 0;
  endtask
  task go(input [1:0] op, fm, input [63:0] x, y, input tr, cp);
    logic [4:0] ds;
    ds = 5'h3 + 5'($urandom % 29);
    rf.mem[1] = x;
    rf.mem[2] = y;
    if (!cp) rq.push_back({4'h5, 69'h0});
    else if (fm[1]) rq.push_back({4'h6, 69'h0});
    else if (tr && (sn(x, fm[0]) || sn(y, fm[0]))) rq.push_back({4'h7, 69'h0});
    else begin
      rq.push_back({4'h8, ds, refv(op, fm[0], x, y)});
      nw++;
    end
    @(posedge clk);
    issueValid <= 1; cpEnabled <= cp; invalidTrapEn <= tr;
    instrWord <= {6'h15, 5'h2, 5'h1, ds, fm, 3'h0, op[1], 1'b0, ~op[0], 3'h3};
    @(posedge clk);
    issueValid <= 0;
    repeat (2) @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (done === 1'b1) begin
      if (rq.size() == 0) chkRes(73'h0, 73'h1);
      else chkRes({destWrite, excValid, excCode,
        destWrite ? {destinationReg, destData} : 69'h0}, rq.pop_front());
    end
    if (rdP) chkWord(regRdata, gq.pop_front());
    rdP <= regRd;
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("ERROR %0t run too long", $time);
    close_out;
  end
  initial begin
    logic [63:0] sg, q, s, x;
    void'($urandom(32'h6439));
    repeat (20) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 4; i++) rd(2'(i), 32'h0);
    wr(1, 32'h1); wr(2, 32'h0); rd(1, 32'h1);
    $display("test 1 done");
    for (int o = 0; o < 4; o++) for (int d = 0; d < 2; d++) begin
      sg = d ? 64'h8000000000000000 : 64'h80000000;
      q = d ? 64'h7FF8000000000001 : 64'h7FC00001;
      s = d ? 64'h7FF0000000000001 : 64'h7F800001;
      x = d ? 64'h4008000000000000 : 64'h40400000;
      go(2'(o), 2'(d), 64'h0, sg, 0, 1);
      go(2'(o), 2'(d), sg, 64'h0, 0, 1);
      go(2'(o), 2'(d), q, x, 0, 1);
      go(2'(o), 2'(d), x | sg, q, 0, 1);
      go(2'(o), 2'(d), q, q | sg | 64'h2, 0, 1);
      go(2'(o), 2'(d), x | sg, x, 0, 1);
      go(2'(o), 2'(d), x, x | sg, 0, 1);
      go(2'(o), 2'(d), {$urandom, $urandom}, {$urandom, $urandom}, 0, 1);
      go(2'(o), 2'(d), s, x, 1, 1);
      go(2'(o), 2'(d), x, s, 1, 1);
      go(2'(o), 2'(d), x, s, 0, 1);
      go(2'(o), 2'(d), s, q, 0, 1);
    end
    $display("test 2 done");
    go(0, 0, x, x, 0, 0);
    go(1, 2, x, x, 0, 0);
    go(2, 2, s, x, 1, 1);
    go(3, 3, x, x, 0, 1);
    foreach (gq[i]) $display("pending read");
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      issueValid <= 1;
      instrWord <= i ? 32'h5000000B : 32'h5400000C;
      @(posedge clk);
      issueValid <= 0;
      repeat (3) @(posedge clk);
    end
    // Frozen unit must not take a held selection word
    @(posedge clk);
    clkEn <= 0;
    issueValid <= 1;
    cpEnabled <= 0;
    instrWord <= 32'h5400000B;
    repeat (3) @(posedge clk);
    issueValid <= 0;
    cpEnabled <= 1;
    @(posedge clk);
    clkEn <= 1;
    repeat (2) @(posedge clk);
    chkWord({31'h0, done | excValid | srcRead}, 32'h0);
    $display("test 3 done");
    rd(2, {16'h0, 16'(nw)});
    #1 chkWord({31'h0, irq}, 32'h1);
    rd(0, 32'h3);
    repeat (3) @(posedge clk);
    #1 chkWord({31'h0, irq}, 32'h0);
    wr(1, 32'h2);
    go(0, 0, x, x, 0, 0);
    #1 chkWord({31'h0, irq}, 32'h1);
    rd(0, 32'h2); wr(1, 32'h0);
    repeat (10) @(posedge clk);
    chkWord(32'(rq.size() + gq.size()), 32'h0);
    $display("test 4 done");
    close_out;
  end
endmodule // testbench
